/* rtl/mdc_top.sv */
// multichannel dma controller with buffer ram and apb registers
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/100ps
module mdc_top
  import mdc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral request lines, indexed by interrupt number
  input wire logic [127:0] per_irq_req,
  input wire logic [10:0] per_ind_off,
  // dedicated peripheral transfer bus
  output logic per_req,
  output logic per_we,
  output logic [15:0] per_addr,
  output logic [15:0] per_wdata,
  input wire logic per_ack,
  input wire logic [15:0] per_rdata,
  // interrupt
  output logic irq
);
  mdc_state_s s_reg; // all registered state
  mdc_state_s s_next; // next value
  // buffer ram, split in two byte lanes
  logic [7:0] ram_lo [MDC_RAM_WORDS];
  logic [7:0] ram_hi [MDC_RAM_WORDS];
  // ram write strobes from the engine and from apb
  logic dma_we_lo;
  logic dma_we_hi;
  logic [9:0] dma_wa;
  logic [15:0] dma_wd;
  logic apb_we_lo;
  logic apb_we_hi;
  logic [9:0] apb_wa;
  // decode helpers
  logic acc; // access phase
  logic [2:0] rch; // addressed channel
  logic [2:0] ridx; // register index in channel
  logic is_ch;
  logic is_ram;
  logic [15:0] rword; // ram word at engine address
  logic [15:0] aword; // ram word at apb address
  logic [10:0] cnt_inc; // element count plus one
  logic [10:0] step; // post-increment step
  logic grant; // some channel granted
  logic [2:0] gch; // granted channel
  mdc_chan_s c; // working channel copy

  assign acc = psel & penable;
  assign rch = paddr[7:5];
  assign ridx = paddr[4:2];
  assign is_ch = (paddr[15:8] == 8'h00);
  assign is_ram = (paddr[15:12] == MDC_A_RAM_BASE[15:12]);
  assign apb_wa = paddr[11:2];
  assign rword = {ram_hi[s_reg.ram_addr[10:1]], ram_lo[s_reg.ram_addr[10:1]]};
  assign aword = {ram_hi[apb_wa], ram_lo[apb_wa]};

  // next state: apb slave, engine, request capture, interrupt
  always_comb
  begin
    s_next = s_reg;
    dma_we_lo = 1'b0;
    dma_we_hi = 1'b0;
    dma_wa = s_reg.ram_addr[10:1];
    dma_wd = s_reg.data;
    apb_we_lo = 1'b0;
    apb_we_hi = 1'b0;
    grant = 1'b0;
    gch = 3'h0;
    c = s_reg.chan[s_reg.ch];
    cnt_inc = 11'h000;
    step = 11'h000;
    // apb answer one cycle into the access phase
    s_next.pready = acc & ~s_reg.pready;
    if (acc & ~s_reg.pready)
    begin
      s_next.prdata = 32'h0000_0000;
      s_next.pslverr = 1'b0;
      if (is_ch && ridx != 3'h7)
      begin
        // per-channel window, each channel its own set
        c = s_reg.chan[rch];
        case (ridx)
          MDC_R_CTRL:
            s_next.prdata = {24'h000000, c.pind, c.postinc, c.mode,
                             c.half, c.bsize, c.dir, c.en};
          MDC_R_REQSEL:
            s_next.prdata = {24'h000000, 1'b0, c.src};
          MDC_R_STA:
            s_next.prdata = {21'h000000, c.sta};
          MDC_R_STB:
            s_next.prdata = {21'h000000, c.stb};
          MDC_R_PERADDR:
            s_next.prdata = {16'h0000, c.paddr};
          MDC_R_LEN:
            s_next.prdata = {22'h000000, c.len};
          default:
            // live status: address, count, buffer select, pending
            s_next.prdata = {6'h00, c.pend, c.pp, 3'h0, c.cnt, c.addr};
        endcase
      end
      else if (paddr == MDC_A_INT_STAT)
        s_next.prdata = {24'h000000, s_reg.ist};
      else if (paddr == MDC_A_INT_EN)
        s_next.prdata = {24'h000000, s_reg.ien};
      else if (paddr == MDC_A_INT_CLR)
        s_next.prdata = 32'h0000_0000; // write-only
      else if (is_ram)
        s_next.prdata = {16'h0000, aword};
      else
        s_next.pslverr = 1'b1; // unmapped
    end
    else
    begin
      // error flag stands only beside pready
      s_next.pslverr = 1'b0;
    end
    // writes take effect at the completing edge
    if (acc & s_reg.pready & pwrite & ~s_reg.pslverr)
    begin
      if (is_ch)
      begin
        c = s_reg.chan[rch];
        case (ridx)
          MDC_R_CTRL:
          begin
            // enabling a stopped channel restarts its block
            if (pwdata[MDC_C_EN] & ~c.en)
            begin
              c.addr = c.sta;
              c.cnt = 10'h000;
              c.pp = 1'b0;
            end
            c.en = pwdata[MDC_C_EN];
            c.dir = pwdata[MDC_C_DIR];
            c.bsize = pwdata[MDC_C_BYTE];
            c.half = pwdata[MDC_C_HALF];
            c.mode = pwdata[MDC_C_MODE+1:MDC_C_MODE];
            c.postinc = pwdata[MDC_C_POSTINC];
            c.pind = pwdata[MDC_C_PIND];
          end
          MDC_R_REQSEL:
          begin
            c.src = pwdata[6:0];
            if (pwdata[MDC_Q_FORCE])
              c.pend = 1'b1; // software-forced request
          end
          MDC_R_STA:
            c.sta = pwdata[10:0];
          MDC_R_STB:
            c.stb = pwdata[10:0];
          MDC_R_PERADDR:
            c.paddr = pwdata[15:0];
          MDC_R_LEN:
            c.len = pwdata[9:0];
          default:
            c = c; // status is read-only
        endcase
        s_next.chan[rch] = c; // only the addressed channel
      end
      else if (paddr == MDC_A_INT_CLR)
        s_next.ist = s_reg.ist & ~pwdata[MDC_NCH-1:0];
      else if (paddr == MDC_A_INT_EN)
        s_next.ien = pwdata[MDC_NCH-1:0];
      else if (is_ram)
      begin
        // processor side of the dual-port ram
        apb_we_lo = pstrb[0];
        apb_we_hi = pstrb[1];
      end
    end
    // transfer engine on its own bus
    case (s_reg.fsm)
      MDC_IDLE:
      begin
        // lowest-numbered pending channel wins
        for (int i = MDC_NCH - 1; i >= 0; i--)
        begin
          if (s_next.chan[i].en & s_next.chan[i].pend)
          begin
            grant = 1'b1;
            gch = 3'(i);
          end
        end
        if (grant)
        begin
          c = s_next.chan[gch];
          c.pend = 1'b0; // one element per grant
          s_next.ch = gch;
          // indirect: peripheral supplies the low bits
          s_next.ram_addr = c.pind ? (c.sta | per_ind_off) : c.addr;
          if (c.dir)
            s_next.fsm = MDC_RAMRD;
          else
          begin
            s_next.per.req = 1'b1;
            s_next.per.we = 1'b0;
            s_next.per.addr = c.paddr;
            s_next.fsm = MDC_PERRD;
          end
          s_next.chan[gch] = c;
        end
      end
      MDC_RAMRD:
      begin
        // fetch element from ram, present to peripheral
        c = s_reg.chan[s_reg.ch]; // engine channel, not the apb one
        s_next.per.req = 1'b1;
        s_next.per.we = 1'b1;
        s_next.per.addr = c.paddr;
        if (c.bsize)
          s_next.per.wdata = {8'h00, s_reg.ram_addr[0] ? rword[15:8]
                                                       : rword[7:0]};
        else
          s_next.per.wdata = rword;
        s_next.fsm = MDC_PERWR;
      end
      MDC_PERWR:
      begin
        if (per_ack)
        begin
          s_next.per.req = 1'b0;
          s_next.per.we = 1'b0;
          s_next.fsm = MDC_FIN;
        end
      end
      MDC_PERRD:
      begin
        if (per_ack)
        begin
          s_next.per.req = 1'b0;
          s_next.data = per_rdata;
          s_next.fsm = MDC_RAMWR;
        end
      end
      MDC_RAMWR:
      begin
        // store element; byte goes to the addressed lane
        c = s_reg.chan[s_reg.ch]; // engine channel, not the apb one
        if (c.bsize)
        begin
          dma_wd = {s_reg.data[7:0], s_reg.data[7:0]};
          dma_we_lo = ~s_reg.ram_addr[0];
          dma_we_hi = s_reg.ram_addr[0];
        end
        else
        begin
          dma_we_lo = 1'b1;
          dma_we_hi = 1'b1;
        end
        s_next.fsm = MDC_FIN;
      end
      MDC_FIN:
      begin
        c = s_next.chan[s_reg.ch];
        cnt_inc = {1'b0, c.cnt} + 11'h001;
        step = c.bsize ? 11'h001 : 11'h002;
        if (c.postinc & ~c.pind)
          c.addr = 11'(c.addr + step);
        c.cnt = cnt_inc[9:0];
        // half-block event instead of completion
        if (c.half && c.len > 10'h001 && cnt_inc == {2'b00, c.len[9:1]})
          s_next.ist[s_reg.ch] = 1'b1;
        if (cnt_inc >= {1'b0, c.len})
        begin
          c.cnt = 10'h000; // block complete
          if (~c.half)
            s_next.ist[s_reg.ch] = 1'b1;
          case (c.mode)
            MDC_M_ONESHOT:
            begin
              c.en = 1'b0; // stop until restarted
              c.addr = c.sta;
            end
            MDC_M_PINGPONG:
            begin
              c.pp = ~c.pp;
              c.addr = c.pp ? c.stb : c.sta;
            end
            default:
              c.addr = c.sta;
          endcase
        end
        s_next.chan[s_reg.ch] = c;
        s_next.fsm = MDC_IDLE;
      end
      default:
      begin
        s_next.fsm = MDC_IDLE;
        s_next.per.req = 1'b0;
      end
    endcase
    // capture requests last so a new one beats the grant clear
    // all channels alike and independent
    for (int i = 0; i < MDC_NCH; i++)
    begin
      if (per_irq_req[s_reg.chan[i].src])
        s_next.chan[i].pend = 1'b1;
    end
    // one level interrupt from enabled sticky bits
    s_next.irq = |(s_next.ist & s_next.ien);
    if (~reset_n)
    begin
      s_next = '0;
      s_next.fsm = MDC_IDLE;
      for (int i = 0; i < MDC_NCH; i++)
        s_next.chan[i].len = 10'h001;
    end
  end

  // state register
  always_ff @(posedge mclk)
  begin
    s_reg <= s_next;
  end

  // buffer ram write ports, engine and processor
  always_ff @(posedge mclk)
  begin
    if (dma_we_lo)
      ram_lo[dma_wa] <= dma_wd[7:0];
    if (dma_we_hi)
      ram_hi[dma_wa] <= dma_wd[15:8];
    if (apb_we_lo)
      ram_lo[apb_wa] <= pwdata[7:0];
    if (apb_we_hi)
      ram_hi[apb_wa] <= pwdata[15:8];
  end

  // outputs straight from flops
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign per_req = s_reg.per.req;
  assign per_we = s_reg.per.we;
  assign per_addr = s_reg.per.addr;
  assign per_wdata = s_reg.per.wdata;
  assign irq = s_reg.irq;
endmodule

/* rtl/mdc_pkg.sv */
// package of constants and types for the multichannel dma controller
// What this block does
// - eight identical independent block transfer channels
// - each channel owns separate control registers
// - direction: buffer ram to peripheral or reverse
// - element size is word or byte
// - channel address register, optional post-increment
// - peripheral supplies low ram address bits
// - one-shot stops after one block
// - continuous reloads start address every block
// - ping-pong alternates two start addresses
// - start on peripheral request or software force
// - each channel picks one of 128 sources
// - source code is peripheral interrupt number
// - interrupt request on full block done
// - optional interrupt at half block instead
// - own transfer bus, no processor stalls
// - buffer ram is 2 kbytes, processor shared
package mdc_pkg;
  localparam int MDC_NCH = 8; // channel count
  localparam int MDC_RAM_BYTES = 2048; // buffer ram size in bytes
  localparam int MDC_RAM_WORDS = MDC_RAM_BYTES / 2; // 16-bit words
  // per-channel register index within the channel window
  localparam logic [2:0] MDC_R_CTRL = 3'h0;
  localparam logic [2:0] MDC_R_REQSEL = 3'h1;
  localparam logic [2:0] MDC_R_STA = 3'h2;
  localparam logic [2:0] MDC_R_STB = 3'h3;
  localparam logic [2:0] MDC_R_PERADDR = 3'h4;
  localparam logic [2:0] MDC_R_LEN = 3'h5;
  localparam logic [2:0] MDC_R_STAT = 3'h6;
  localparam logic [15:0] MDC_CH_STRIDE = 16'h0020; // bytes per channel
  // global interrupt registers
  localparam logic [15:0] MDC_A_INT_STAT = 16'h0100;
  localparam logic [15:0] MDC_A_INT_CLR = 16'h0104;
  localparam logic [15:0] MDC_A_INT_EN = 16'h0108;
  localparam logic [15:0] MDC_A_RAM_BASE = 16'h1000; // ram window base
  // control register field positions
  localparam int MDC_C_EN = 0;
  localparam int MDC_C_DIR = 1;
  localparam int MDC_C_BYTE = 2;
  localparam int MDC_C_HALF = 3;
  localparam int MDC_C_MODE = 4; // two bits
  localparam int MDC_C_POSTINC = 6;
  localparam int MDC_C_PIND = 7;
  localparam int MDC_Q_FORCE = 7; // in reqsel register
  // block modes
  localparam logic [1:0] MDC_M_CONT = 2'h0;
  localparam logic [1:0] MDC_M_ONESHOT = 2'h1;
  localparam logic [1:0] MDC_M_PINGPONG = 2'h2;
  // engine states, one-hot
  typedef enum logic [5:0] {
    MDC_IDLE = 6'b000001,
    MDC_RAMRD = 6'b000010,
    MDC_PERWR = 6'b000100,
    MDC_PERRD = 6'b001000,
    MDC_RAMWR = 6'b010000,
    MDC_FIN = 6'b100000
  } mdc_fsm_e;
  // one channel's configuration and progress
  typedef struct packed {
    logic en;
    logic dir; // 1: ram to peripheral
    logic bsize; // 1: byte elements
    logic half;
    logic [1:0] mode;
    logic postinc;
    logic pind;
    logic [6:0] src;
    logic pend;
    logic [10:0] sta;
    logic [10:0] stb;
    logic [15:0] paddr;
    logic [9:0] len;
    logic [10:0] addr;
    logic [9:0] cnt;
    logic pp;
  } mdc_chan_s;
  // peripheral transfer bus outputs
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mdc_per_s;
  // whole module state
  typedef struct packed {
    mdc_fsm_e fsm;
    logic [2:0] ch;
    logic [10:0] ram_addr;
    logic [15:0] data;
    mdc_chan_s [MDC_NCH-1:0] chan;
    logic [MDC_NCH-1:0] ist;
    logic [MDC_NCH-1:0] ien;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    mdc_per_s per;
  } mdc_state_s;
endpackage

/* tb/mdc_sva.sv */
// port assertions for the dma controller
`timescale 1ns/100ps
module mdc_sva
  import mdc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // transfer bus and interrupt
  input wire logic per_req,
  input wire logic per_we,
  input wire logic [15:0] per_addr,
  input wire logic [15:0] per_wdata,
  input wire logic per_ack,
  input wire logic irq
);
  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // one wait state, then a single answer cycle
  chk_apb_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  chk_apb_once: assert property (pready |=> !pready)
    else $error("pready held");
  chk_apb_ctx: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  chk_err_pair: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  chk_clr_zero: assert property
    (pready && !pwrite && paddr == MDC_A_INT_CLR |-> prdata == 32'h0)
    else $error("clear register reads nonzero");
  // request and its qualifiers stand until acknowledged
  chk_req_hold: assert property
    (per_req && !per_ack |=> per_req &&
      $stable({per_we, per_addr, per_wdata}))
    else $error("request changed before ack");
  chk_req_gap: assert property (per_req && per_ack |=> !per_req [*2])
    else $error("request too soon after ack");
  chk_irq_mask: assert property
    (pready && pwrite && paddr == MDC_A_INT_EN && pwdata[7:0] == 8'h0
      |-> ##2 !irq)
    else $error("irq not masked");
endmodule

/* tb/mdc_per.sv */
// peripheral model answering the transfer bus
`timescale 1ns/100ps
module mdc_per
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // transfer bus
  input wire logic per_req,
  input wire logic per_we,
  input wire logic [15:0] per_addr,
  input wire logic [15:0] per_wdata,
  output logic per_ack,
  output logic [15:0] per_rdata,
  // bench control and observation
  input wire logic slow,
  output int acks,
  output logic [15:0] wd,
  output logic [15:0] wa
);
  int dly; // stall cycles spent so far
  // answer at once, or after three stall cycles when slow
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      per_ack <= 1'b0;
      per_rdata <= 16'h0;
      acks <= 0;
      dly <= 0;
    end
    else if (per_req && !per_ack && dly >= 3 * slow)
    begin
      per_ack <= 1'b1;
      per_rdata <= 16'(acks * 263 + 17);
      acks <= acks + 1;
      dly <= 0;
      if (per_we)
      begin
        wd <= per_wdata;
        wa <= per_addr;
      end
    end
    else
    begin
      per_ack <= 1'b0;
      per_rdata <= ~per_rdata; // no stale data outside answers
      dly <= (per_req && !per_ack) ? dly + 1 : 0;
    end
  end
endmodule

/* tb/tb_multichannel_dma_controller.sv */
// self-checking bench for the multichannel dma controller
`timescale 1ns/100ps
module tb_multichannel_dma_controller
  import mdc_pkg::*;
;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf; // whole words only
  logic [127:0] per_irq_req = '0;
  logic [10:0] per_ind_off = 11'h0; // low ram bits in indirect mode
  logic slow = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, per_req, per_we, per_ack, irq, err;
  logic [15:0] per_addr, per_wdata, per_rdata, wd, wa;
  int acks, i, b;
  int mismatches = 0;
  int tests_run = 0;
  int seed = 70876;
  logic [15:0] mem [0:16]; // words written to the buffer ram
  mdc_top mdc_top_inst (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .per_irq_req(per_irq_req), .per_ind_off(per_ind_off),
    .per_req(per_req), .per_we(per_we), .per_addr(per_addr),
    .per_wdata(per_wdata), .per_ack(per_ack), .per_rdata(per_rdata),
    .irq(irq));
  mdc_per mdc_per_inst (.mclk(mclk), .reset_n(reset_n), .per_req(per_req),
    .per_we(per_we), .per_addr(per_addr), .per_wdata(per_wdata),
    .per_ack(per_ack), .per_rdata(per_rdata), .slow(slow), .acks(acks),
    .wd(wd), .wa(wa));
  // free running clock
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  // verdict and end of run
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // compare and report
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // channel register byte address
  function automatic logic [15:0] ca(int c, logic [2:0] r);
    return 16'(c * 32) + {11'h0, r, 2'b00};
  endfunction
  // low byte the peripheral model returns on answer n
  function automatic logic [7:0] pbyte(int n);
    return 8'(n * 263 + 17);
  endfunction
  // one apb transfer, result left in rd and err
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 50 && pready !== 1'b1; n++)
      @(posedge mclk);
    if (n == 50)
    begin
      chk(pready, 1'b1);
      finish_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // start one element by request line or by software force
  task go(input int c, input int s, input logic f);
    int k;
    int n;
    k = acks;
    slow <= 1'($random(seed));
    if (f)
      apb(1'b1, ca(c, MDC_R_REQSEL), 32'(s) | 32'h80);
    else
    begin
      per_irq_req[s] <= 1'b1;
      @(posedge mclk);
      per_irq_req[s] <= 1'b0;
    end
    for (n = 0; n < 50 && acks == k; n++)
      @(posedge mclk);
    if (acks == k)
    begin
      chk(acks, k + 1);
      finish_test;
    end
    repeat (4) @(posedge mclk);
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    // reset values, unmapped and write-only reads
    apb(1'b0, ca(0, MDC_R_LEN), 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 16'h0200, 32'h0);
    chk(err, 1'b1);
    apb(1'b0, MDC_A_INT_CLR, 32'h0);
    chk(rd, 32'h0);
    // random words into the buffer ram, then read back
    for (i = 0; i < 17; i++)
    begin
      mem[i] = 16'($random(seed));
      apb(1'b1, MDC_A_RAM_BASE + 16'(i * 4), {16'h0, mem[i]});
    end
    for (i = 0; i < 17; i++)
    begin
      apb(1'b0, MDC_A_RAM_BASE + 16'(i * 4), 32'h0);
      chk(rd, {16'h0, mem[i]});
    end
    // one-shot word block from the ram out to a peripheral
    apb(1'b1, MDC_A_INT_EN, 32'hff);
    apb(1'b1, ca(0, MDC_R_PERADDR), 32'h1234);
    apb(1'b1, ca(0, MDC_R_LEN), 32'h3);
    apb(1'b1, ca(0, MDC_R_REQSEL), 32'h21);
    apb(1'b1, ca(0, MDC_R_CTRL), 32'h53);
    apb(1'b0, ca(1, MDC_R_PERADDR), 32'h0);
    chk(rd, 32'h0);
    for (i = 0; i < 3; i++)
    begin
      go(0, 33, 1'b0);
      chk(wd, mem[i]);
    end
    chk(wa, 16'h1234);
    chk(irq, 1'b1);
    apb(1'b0, ca(0, MDC_R_CTRL), 32'h0);
    chk(rd, 32'h52);
    b = acks;
    per_irq_req[33] <= 1'b1;
    @(posedge mclk);
    per_irq_req[33] <= 1'b0;
    repeat (20) @(posedge mclk);
    chk(acks, b);
    // mask, unmask and clear the completion flag
    apb(1'b1, MDC_A_INT_EN, 32'h0);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    apb(1'b1, MDC_A_INT_EN, 32'hff);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b1);
    apb(1'b1, MDC_A_INT_CLR, 32'h1);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    // half-block flag on a continuous byte block into the ram
    apb(1'b1, ca(1, MDC_R_STA), 32'h100);
    apb(1'b1, ca(1, MDC_R_LEN), 32'h4);
    apb(1'b1, ca(1, MDC_R_REQSEL), 32'h3c);
    apb(1'b1, ca(1, MDC_R_CTRL), 32'h4d);
    b = acks;
    for (i = 0; i < 4; i++)
    begin
      go(1, 60, 1'b0);
      apb(1'b0, MDC_A_INT_STAT, 32'h0);
      chk(rd, (i == 1) ? 32'h2 : 32'h0);
      apb(1'b1, MDC_A_INT_CLR, 32'h2);
    end
    apb(1'b0, ca(1, MDC_R_STAT), 32'h0);
    chk(rd, 32'h100);
    for (i = 0; i < 2; i++)
    begin
      apb(1'b0, MDC_A_RAM_BASE + 16'h200 + 16'(i * 4), 32'h0);
      chk(rd, {16'h0, pbyte(b + 2 * i + 1), pbyte(b + 2 * i)});
    end
    // ping-pong blocks started by software
    apb(1'b1, ca(2, MDC_R_STA), 32'h10);
    apb(1'b1, ca(2, MDC_R_STB), 32'h20);
    apb(1'b1, ca(2, MDC_R_LEN), 32'h1);
    apb(1'b1, ca(2, MDC_R_CTRL), 32'h23);
    for (i = 0; i < 3; i++)
    begin
      go(2, 70, 1'b1);
      chk(wd, mem[8 + 8 * (i % 2)]);
    end
    // indirect ram address from the peripheral's offset bits
    per_ind_off <= {6'h00, 4'($random(seed)), 1'b0};
    apb(1'b1, ca(3, MDC_R_CTRL), 32'hc3);
    go(3, 5, 1'b1);
    chk(wd, mem[per_ind_off[10:1]]);
    // mid-run reset returns registers to their reset values
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    chk(irq, 1'b0);
    apb(1'b0, ca(1, MDC_R_LEN), 32'h0);
    chk(rd, 32'h1);
    finish_test;
  end
endmodule
bind mdc_top mdc_sva mdc_sva_inst (.mclk(mclk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .per_req(per_req), .per_we(per_we), .per_addr(per_addr),
  .per_wdata(per_wdata), .per_ack(per_ack), .irq(irq));
